// ==== hw/lcd_pkg.sv ====
`default_nettype none

package lcd_pkg;

    // ------------------------------------------------------------
    // panel geometry
    // ------------------------------------------------------------
    localparam int NUM_COM   = 4;
    localparam int NUM_SEG   = 27;
    localparam int SEG_FIRST = 4;
    localparam int RAM_DEPTH = 35;
    localparam int NUM_PIX   = NUM_SEG * NUM_COM;

    localparam logic [5:0] ADDR_MAX   = 6'h22;
    localparam logic [5:0] ADDR_FIRST = 6'h00;

    // ------------------------------------------------------------
    // command byte layout
    // ------------------------------------------------------------
    localparam int CONT_BIT      = 7;
    localparam int DISP_ON_BIT   = 3;
    localparam int BIAS_BIT      = 2;
    localparam int ADDR_MSB_BIT  = 2;
    localparam int SWRST_BIT     = 1;
    localparam int FORCE_ON_BIT  = 1;
    localparam int FORCE_OFF_BIT = 0;

    localparam logic [1:0] MODE_TAG  = 2'h2;
    localparam logic [1:0] ADDR_TAG  = 2'h0;
    localparam logic [1:0] PANEL_TAG = 2'h1;
    localparam logic [3:0] SETUP_TAG = 4'hD;
    localparam logic [3:0] BLINK_TAG = 4'hE;
    localparam logic [4:0] OVR_TAG   = 5'h1F;

    // ------------------------------------------------------------
    // reset values and blink rates
    // ------------------------------------------------------------
    localparam logic [4:0] PANEL_RST = 5'h02;

    localparam logic [1:0] BLINK_OFF     = 2'h0;
    localparam logic [1:0] BLINK_HALF_HZ = 2'h1;
    localparam logic [1:0] BLINK_ONE_HZ  = 2'h2;
    localparam logic [1:0] BLINK_TWO_HZ  = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 100_000_000;
    localparam int FRAME_HZ     = 80;
    localparam int FRAME_CYCLES = CLK_HZ / FRAME_HZ;
    localparam int FRAME_W      = 21;
    // frames per visibility toggle: half a blink period
    localparam logic [6:0] TOG_HALF_HZ = 7'(FRAME_HZ);
    localparam logic [6:0] TOG_ONE_HZ  = 7'(FRAME_HZ / 2);
    localparam logic [6:0] TOG_TWO_HZ  = 7'(FRAME_HZ / 4);
    localparam logic [3:0] SCLK_HALF   = 4'h6;

    // ------------------------------------------------------------
    // controller registers
    // ------------------------------------------------------------
    localparam int         AXI_AW   = 4;
    localparam logic [3:0] TX_OFS   = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] CTRL_OFS = 4'h8;
    localparam int         STAT_BUSY_BIT = 0;
    localparam int         STAT_SEL_BIT  = 1;
    localparam int         CTRL_SEL_BIT  = 0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_LOW  = 2'h1,
        H_HIGH = 2'h3,
        H_GAP  = 2'h2
    } host_state_e;

endpackage : lcd_pkg

`default_nettype wire

// ==== hw/lcd_link_if.sv ====
`default_nettype none

interface lcd_link_if;
    logic csb_n;
    logic sclk;
    logic serial_in;

    modport host (output csb_n, output sclk, output serial_in);
    modport dev  (input csb_n, input sclk, input serial_in);
endinterface : lcd_link_if

`default_nettype wire

// ==== hw/lcd_host_ctrl.sv ====
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`default_nettype none

module lcd_host_ctrl
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    lcd_link_if.host                       link,
    input  wire logic [lcd_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [lcd_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);

    typedef struct packed {
        logic                 awready;
        logic                 wready;
        logic                 aw_got;
        logic [3:0]           aw_addr;
        logic                 w_got;
        logic [7:0]           w_data;
        logic                 w_strb0;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        lcd_pkg::host_state_e st;
        logic [3:0]           div;
        logic [2:0]           bit_cnt;
        logic [7:0]           shreg;
        logic                 sel_req;
        logic                 csb_n;
        logic                 sclk;
        logic                 sd;
    } host_s;

    localparam host_s RST_STATE = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, csb_n: 1'b1,
                                    st: lcd_pkg::H_IDLE, default: '0};

    host_s r;
    host_s n;
    logic  busy;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        n    = r;
        busy = (r.st != lcd_pkg::H_IDLE);
        if (r.awready && s_axi_awvalid)
        begin
            n.aw_got  = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (r.wready && s_axi_wvalid)
        begin
            n.w_got   = 1'b1;
            n.w_data  = s_axi_wdata[7:0];
            n.w_strb0 = s_axi_wstrb[0];
        end
        if (r.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        // tx waits for the shifter instead of being dropped
        if (r.aw_got && r.w_got && !r.bvalid && !(r.aw_addr == lcd_pkg::TX_OFS && busy))
        begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = lcd_pkg::RESP_OKAY;
            if (r.aw_addr == lcd_pkg::TX_OFS)
            begin
                if (r.csb_n)
                    n.bresp = lcd_pkg::RESP_SLVERR;
                else if (r.w_strb0)
                begin
                    n.shreg   = r.w_data;
                    n.sd      = r.w_data[7];
                    n.bit_cnt = 3'h0;
                    n.div     = 4'h0;
                    n.st      = lcd_pkg::H_LOW;
                end
            end
            else if (r.aw_addr == lcd_pkg::CTRL_OFS)
            begin
                if (r.w_strb0)
                    n.sel_req = r.w_data[lcd_pkg::CTRL_SEL_BIT];
            end
            else if (r.aw_addr != lcd_pkg::STAT_OFS)
                n.bresp = lcd_pkg::RESP_SLVERR;
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready  = !n.w_got && !n.bvalid;

        if (r.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        if (r.arready && s_axi_arvalid)
        begin
            n.rvalid = 1'b1;
            n.rdata  = 32'h0;
            n.rresp  = lcd_pkg::RESP_OKAY;
            if (s_axi_araddr == lcd_pkg::STAT_OFS)
            begin
                n.rdata[lcd_pkg::STAT_BUSY_BIT] = busy || (r.aw_got && r.w_got);
                n.rdata[lcd_pkg::STAT_SEL_BIT]  = !r.csb_n;
            end
            else if (s_axi_araddr == lcd_pkg::CTRL_OFS)
                n.rdata[lcd_pkg::CTRL_SEL_BIT] = r.sel_req;
            else if (s_axi_araddr != lcd_pkg::TX_OFS)
                n.rresp = lcd_pkg::RESP_SLVERR;
        end
        n.arready = !n.rvalid;

        // ------------------------------------------------------------
        // serial shifter: data changes with sclk low, taken on rise
        // ------------------------------------------------------------
        unique case (r.st)
            lcd_pkg::H_IDLE:
            begin
                // select high resets the far interface, low opens a frame
                n.csb_n = !r.sel_req;
                n.sclk  = 1'b0;
            end
            lcd_pkg::H_LOW:
            begin
                n.div = r.div + 4'h1;
                if (r.div == lcd_pkg::SCLK_HALF - 4'h1)
                begin
                    n.div  = 4'h0;
                    n.sclk = 1'b1;
                    n.st   = lcd_pkg::H_HIGH;
                end
            end
            lcd_pkg::H_HIGH:
            begin
                n.div = r.div + 4'h1;
                if (r.div == lcd_pkg::SCLK_HALF - 4'h1)
                begin
                    n.div  = 4'h0;
                    n.sclk = 1'b0;
                    if (r.bit_cnt == 3'h7)
                        n.st = lcd_pkg::H_GAP;
                    else
                    begin
                        n.bit_cnt = r.bit_cnt + 3'h1;
                        n.shreg   = {r.shreg[6:0], 1'b0};
                        n.sd      = r.shreg[6];
                        n.st      = lcd_pkg::H_LOW;
                    end
                end
            end
            lcd_pkg::H_GAP:
            begin
                n.div = r.div + 4'h1;
                if (r.div == lcd_pkg::SCLK_HALF - 4'h1)
                begin
                    n.div = 4'h0;
                    n.st  = lcd_pkg::H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= RST_STATE;
        else
            r <= n;
    end

    assign s_axi_awready  = r.awready;
    assign s_axi_wready   = r.wready;
    assign s_axi_bvalid   = r.bvalid;
    assign s_axi_bresp    = r.bresp;
    assign s_axi_arready  = r.arready;
    assign s_axi_rvalid   = r.rvalid;
    assign s_axi_rdata    = r.rdata;
    assign s_axi_rresp    = r.rresp;
    assign link.csb_n     = r.csb_n;
    assign link.sclk      = r.sclk;
    assign link.serial_in = r.sd;

endmodule : lcd_host_ctrl

`default_nettype wire

// ==== hw/lcd_seg_driver.sv ====
`default_nettype none

// Behaviour
// - blink rate field: off, 0.5, 1, 2 Hz
// - override bits force on/off, reset normal
// - force on lights every pixel
// - force off darkens every pixel
// - overrides only act while display on
// - override command leaves ram untouched
// - force off beats force on
// - address is segment, bits are commons
// - addresses 00h to 03h never shown
// - state undefined until initialisation done
// - select high resets serial interface
// - host sends software reset first
// - commands ignored while supply off
// - power-on and software reset reinitialise
// - host toggles select then soft-resets
// - host display on and off sequences
// - top bit picks command or data next
// - address 00h to 22h, wraps after 22h
// - display off blanks all outputs
module lcd_seg_driver
#(
    parameter int FRAME_CYCLES = lcd_pkg::FRAME_CYCLES
)
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    lcd_link_if.dev                         link,
    input  wire logic                       supply_ok,
    output logic [lcd_pkg::NUM_PIX-1:0]     pixel_out,
    output logic                            display_active
);

    typedef struct packed {
        logic [3:0]                         sync1;
        logic [3:0]                         sync2;
        logic                               sclk_prev;
        logic [7:0]                         shreg;
        logic [2:0]                         bit_cnt;
        logic                               data_mode;
        logic                               disp_on;
        logic                               bias_half;
        logic                               addr_msb;
        logic                               force_on;
        logic                               force_off;
        logic [1:0]                         blink_rate;
        logic [4:0]                         panel_cfg;
        logic [5:0]                         addr;
        logic [lcd_pkg::RAM_DEPTH*4-1:0]    ram;
        logic [lcd_pkg::FRAME_W-1:0]        frame_cnt;
        logic [6:0]                         blink_cnt;
        logic                               blink_hide;
        logic [lcd_pkg::NUM_PIX-1:0]        pixel;
    } dev_s;

    localparam dev_s RST_STATE = '{panel_cfg: lcd_pkg::PANEL_RST, sync1: 4'h8, sync2: 4'h8,
                                   default: '0};
    localparam logic [lcd_pkg::FRAME_W-1:0] FRAME_LAST = lcd_pkg::FRAME_W'(FRAME_CYCLES - 1);

    function automatic logic [5:0] addr_step(input logic [5:0] a);
        addr_step = (a == lcd_pkg::ADDR_MAX) ? lcd_pkg::ADDR_FIRST : a + 6'h1;
    endfunction : addr_step

    function automatic logic [6:0] toggle_frames(input logic [1:0] rate);
        unique case (rate)
            lcd_pkg::BLINK_HALF_HZ: toggle_frames = lcd_pkg::TOG_HALF_HZ;
            lcd_pkg::BLINK_ONE_HZ:  toggle_frames = lcd_pkg::TOG_ONE_HZ;
            lcd_pkg::BLINK_TWO_HZ:  toggle_frames = lcd_pkg::TOG_TWO_HZ;
            lcd_pkg::BLINK_OFF:     toggle_frames = 7'h0;
        endcase
    endfunction : toggle_frames

    dev_s       r;
    dev_s       n;
    logic       csb_n;
    logic       sclk;
    logic       sd;
    logic       pwr;
    logic       byte_done;
    logic       soft_rst;
    logic       frame_tick;
    logic [7:0] byte_v;
    logic [5:0] a0;
    logic [5:0] a1;
    logic [5:0] a_set;

    always_comb
    begin
        n          = r;
        soft_rst   = 1'b0;
        byte_done  = 1'b0;
        a0         = r.addr;
        a1         = addr_step(r.addr);
        a_set      = 6'h0;
        n.sync1    = {link.csb_n, link.sclk, link.serial_in, supply_ok};
        n.sync2    = r.sync1;
        csb_n      = r.sync2[3];
        sclk       = r.sync2[2];
        sd         = r.sync2[1];
        pwr        = r.sync2[0];
        n.sclk_prev = sclk;
        byte_v     = {r.shreg[6:0], sd};

        // ------------------------------------------------------------
        // serial receive
        // ------------------------------------------------------------
        if (csb_n)
        begin
            n.bit_cnt   = 3'h0;
            n.data_mode = 1'b0;
        end
        else if (sclk && !r.sclk_prev)
        begin
            n.shreg   = byte_v;
            n.bit_cnt = r.bit_cnt + 3'h1;
            byte_done = (r.bit_cnt == 3'h7);
        end

        // ------------------------------------------------------------
        // byte decode
        // ------------------------------------------------------------
        if (byte_done && pwr)
        begin
            if (r.data_mode)
            begin
                // dummy addresses 00h-03h are stored like any other
                n.ram[a0*4 +: 4] = byte_v[7:4];
                n.ram[a1*4 +: 4] = byte_v[3:0];
                n.addr           = addr_step(a1);
            end
            else
            begin
                n.data_mode = !byte_v[lcd_pkg::CONT_BIT];
                if (byte_v[6:5] == lcd_pkg::MODE_TAG)
                begin
                    n.disp_on   = byte_v[lcd_pkg::DISP_ON_BIT];
                    n.bias_half = byte_v[lcd_pkg::BIAS_BIT];
                end
                else if (byte_v[6:5] == lcd_pkg::ADDR_TAG)
                begin
                    a_set  = {r.addr_msb, byte_v[4:0]};
                    n.addr = (a_set > lcd_pkg::ADDR_MAX) ? lcd_pkg::ADDR_FIRST : a_set;
                end
                else if (byte_v[6:5] == lcd_pkg::PANEL_TAG)
                    n.panel_cfg = byte_v[4:0];
                else if (byte_v[6:3] == lcd_pkg::SETUP_TAG)
                begin
                    if (byte_v[lcd_pkg::SWRST_BIT])
                        soft_rst = 1'b1;
                    else
                        n.addr_msb = byte_v[lcd_pkg::ADDR_MSB_BIT];
                end
                else if (byte_v[6:3] == lcd_pkg::BLINK_TAG)
                    n.blink_rate = byte_v[1:0];
                else if (byte_v[6:2] == lcd_pkg::OVR_TAG)
                begin
                    // only the two flags move, ram is not touched
                    n.force_on  = byte_v[lcd_pkg::FORCE_ON_BIT];
                    n.force_off = byte_v[lcd_pkg::FORCE_OFF_BIT];
                end
            end
        end

        // ------------------------------------------------------------
        // supply loss and software reset return settings to defaults
        // ------------------------------------------------------------
        if (soft_rst || !pwr)
        begin
            n.data_mode  = 1'b0;
            n.disp_on    = 1'b0;
            n.bias_half  = 1'b0;
            n.addr_msb   = 1'b0;
            n.force_on   = 1'b0;
            n.force_off  = 1'b0;
            n.blink_rate = lcd_pkg::BLINK_OFF;
            n.panel_cfg  = lcd_pkg::PANEL_RST;
            n.addr       = lcd_pkg::ADDR_FIRST;
        end

        // ------------------------------------------------------------
        // frame and blink timing
        // ------------------------------------------------------------
        frame_tick  = (r.frame_cnt == FRAME_LAST);
        n.frame_cnt = frame_tick ? '0 : r.frame_cnt + 1'b1;
        if (r.blink_rate == lcd_pkg::BLINK_OFF)
        begin
            n.blink_cnt  = 7'h0;
            n.blink_hide = 1'b0;
        end
        else if (frame_tick)
        begin
            if (r.blink_cnt >= toggle_frames(r.blink_rate) - 7'h1)
            begin
                n.blink_cnt  = 7'h0;
                n.blink_hide = !r.blink_hide;
            end
            else
                n.blink_cnt = r.blink_cnt + 7'h1;
        end

        // ------------------------------------------------------------
        // pixel map: segment s, common c from ram bit c at address s+4
        // ------------------------------------------------------------
        for (int s = 0; s < lcd_pkg::NUM_SEG; s++)
        begin
            for (int c = 0; c < lcd_pkg::NUM_COM; c++)
            begin
                n.pixel[s*lcd_pkg::NUM_COM+c] =
                    r.disp_on && !r.force_off &&
                    (r.force_on ||
                     (!r.blink_hide && r.ram[(s+lcd_pkg::SEG_FIRST)*lcd_pkg::NUM_COM+c]));
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= RST_STATE;
        else
            r <= n;
    end

    assign pixel_out      = r.pixel;
    assign display_active = r.disp_on;

endmodule : lcd_seg_driver

`default_nettype wire

// ==== hw/zz_unused_guard.sv ====
`default_nettype none
`default_nettype wire

// ==== tb/lcd_link_props.sv ====
`default_nettype none

module lcd_link_props
(
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        csb_n,
    input wire logic                        sclk,
    input wire logic                        serial_in,
    input wire logic [lcd_pkg::NUM_PIX-1:0] pixel_out,
    input wire logic                        display_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // wire framing
    // ------------------------------------------------------------
    chk_sclk_idle: assert property (csb_n |-> !sclk)
        else $error("sclk moved while deselected");
    chk_sel_quiet: assert property ($changed(csb_n) |-> !sclk && !$past(sclk))
        else $error("select moved during a bit");
    chk_data_hold: assert property (sclk && $past(sclk) |-> $stable(serial_in))
        else $error("data moved while sclk high");
    chk_high_len: assert property ($rose(sclk) |-> sclk[*6] ##1 !sclk)
        else $error("sclk high phase length wrong");
    chk_low_len: assert property ($fell(sclk) |-> (!sclk)[*6])
        else $error("sclk low phase too short");

    // ------------------------------------------------------------
    // display outputs
    // ------------------------------------------------------------
    chk_off_blank: assert property (!display_active && !$past(display_active) |-> pixel_out == '0)
        else $error("pixels lit while display off");
    chk_force_gate: assert property (pixel_out == '1 |-> $past(display_active))
        else $error("all pixels lit while display off");
    chk_on_cause: assert property ($rose(display_active) |-> !$past(csb_n, 5))
        else $error("display on without selected command");
endmodule : lcd_link_props

`default_nettype wire

// ==== tb/lcd_blink_pixel_init_control_tb.sv ====
`default_nettype none

module lcd_blink_pixel_init_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FRAME = 20;
    localparam int NP    = lcd_pkg::NUM_PIX;
    logic          clk       = 1'h0;
    logic          rst       = 1'h1;
    logic          supply_ok = 1'h1;
    logic [3:0]    awaddr    = 4'h0;
    logic [3:0]    araddr    = 4'h0;
    logic [31:0]   wdata     = 32'h0;
    logic          awvalid   = 1'h0;
    logic          wvalid    = 1'h0;
    logic          arvalid   = 1'h0;
    logic          awready, wready, bvalid, arready, rvalid, display_active;
    logic [1:0]    bresp, rresp;
    logic [31:0]   rdata;
    logic [NP-1:0] pixel_out;
    logic [3:0]    ram_m [lcd_pkg::RAM_DEPTH];
    int            failures  = 0;
    int            checks    = 0;
    int            cyc       = 0;
    int            tog [3]   = '{int'(lcd_pkg::TOG_HALF_HZ), int'(lcd_pkg::TOG_ONE_HZ), int'(lcd_pkg::TOG_TWO_HZ)};

    lcd_link_if link ();
    lcd_host_ctrl lcd_host_ctrl_i (.clk(clk), .rst(rst), .link(link), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'h1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1));
    lcd_seg_driver #(.FRAME_CYCLES(FRAME)) lcd_seg_driver_i (.clk(clk), .rst(rst), .link(link),
        .supply_ok(supply_ok), .pixel_out(pixel_out), .display_active(display_active));
    lcd_link_props lcd_link_props_i (.clk(clk), .rst(rst), .csb_n(link.csb_n), .sclk(link.sclk),
        .serial_in(link.serial_in), .pixel_out(pixel_out), .display_active(display_active));

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // bus tasks and compares
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            failures++;
            close_out();
        end
    end

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic cmp_pix(input logic [NP-1:0] e);
        @(negedge clk);
        checks++;
        if (pixel_out !== e)
        begin
            failures++;
            $display("unexpected pixel_out expected %h seen %h", e, pixel_out);
        end
    endtask : cmp_pix

    task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
        logic done;
        done = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!done)
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid)
            begin
                r = bresp;
                done = 1'h1;
            end
        end
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'h0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        while (!done)
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                done = 1'h1;
            end
        end
    endtask : rd

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        cmp("rdata", e, d);
        cmp("rresp", 32'(er), 32'(r));
    endtask : rd_chk

    task automatic sel(input logic v);
        logic [1:0] r;
        wr(lcd_pkg::CTRL_OFS, {7'h0, v}, r);
    endtask : sel

    // one link byte, then wait for the shifter to go idle
    task automatic tx(input logic [7:0] b);
        logic [31:0] d;
        logic [1:0]  r;
        wr(lcd_pkg::TX_OFS, b, r);
        cmp("bresp", 32'(lcd_pkg::RESP_OKAY), 32'(r));
        d = 32'h1;
        while (d[lcd_pkg::STAT_BUSY_BIT])
            rd(lcd_pkg::STAT_OFS, d, r);
        repeat (8) @(posedge clk);
    endtask : tx

    task automatic blink_gap(input int e);
        logic [NP-1:0] p;
        int            n;
        @(negedge clk);
        p = pixel_out;
        while (pixel_out === p)
            @(negedge clk);
        p = pixel_out;
        n = 0;
        while (pixel_out === p)
        begin
            @(negedge clk);
            n++;
        end
        cmp("blink interval", 32'(e), 32'(n));
    endtask : blink_gap

    function automatic logic [NP-1:0] pat();
        logic [NP-1:0] p;
        for (int s = 0; s < lcd_pkg::NUM_SEG; s++)
            for (int c = 0; c < lcd_pkg::NUM_COM; c++)
                p[s*lcd_pkg::NUM_COM+c] = ram_m[s+lcd_pkg::SEG_FIRST][c];
        return p;
    endfunction : pat

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [1:0] r;
        logic [7:0] b;
        int         a;
        foreach (ram_m[i]) ram_m[i] = 4'h0;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        cmp_pix('0);
        rd_chk(lcd_pkg::STAT_OFS, 32'h0, lcd_pkg::RESP_OKAY);
        rd_chk(4'hC, 32'h0, lcd_pkg::RESP_SLVERR);
        wr(lcd_pkg::TX_OFS, 8'hC8, r);
        cmp("tx deselected", 32'(lcd_pkg::RESP_SLVERR), 32'(r));
        sel(1'h1);
        rd_chk(lcd_pkg::STAT_OFS, 32'h2, lcd_pkg::RESP_OKAY);
        rd_chk(lcd_pkg::CTRL_OFS, 32'h1, lcd_pkg::RESP_OKAY);
        tx(8'hEA);
        tx(8'h00);
        a = 0;
        for (int k = 0; k < 20; k++)
        begin
            b = 8'(k * 29 + 7);
            ram_m[a] = b[7:4];
            a = (a == int'(lcd_pkg::ADDR_MAX)) ? 0 : a + 1;
            ram_m[a] = b[3:0];
            a = (a == int'(lcd_pkg::ADDR_MAX)) ? 0 : a + 1;
            tx(b);
        end
        sel(1'h0);
        sel(1'h1);
        for (int i = 0; i < 4; i++) tx(8'(32'hC8FCF0BF >> 8 * i));
        cmp_pix(pat());
        cmp("display_active", 32'h1, 32'(display_active));
        tx(8'hFE);
        cmp_pix('1);
        tx(8'hFD);
        cmp_pix('0);
        tx(8'hFF);
        cmp_pix('0);
        tx(8'hFC);
        cmp_pix(pat());
        foreach (tog[i])
        begin
            tx(8'hF1 + 8'(i));
            blink_gap(tog[i] * FRAME);
        end
        tx(8'hF0);
        cmp_pix(pat());
        tx(8'hC0);
        cmp_pix('0);
        tx(8'hFE);
        cmp_pix('0);
        tx(8'hC8);
        cmp_pix('1);
        tx(8'hEA);
        cmp_pix('0);
        tx(8'hC8);
        cmp_pix(pat());
        supply_ok <= 1'h0;
        repeat (8) @(posedge clk);
        tx(8'hC8);
        cmp("display_active", 32'h0, 32'(display_active));
        supply_ok <= 1'h1;
        repeat (8) @(posedge clk);
        tx(8'hC8);
        cmp("display_active", 32'h1, 32'(display_active));
        sel(1'h0);
        close_out();
    end
endmodule : lcd_blink_pixel_init_control_tb

`default_nettype wire
